//--- hdl/thrm_pkg.sv
// Constants shared by the host register map of the component transcoder.
package thrm_pkg;

    // ------------------------------------------------------------------
    // Host port, coefficient and map sizes
    // ------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int COEF_W = 13;
    localparam int NUM_LOC = 23;
    localparam int COEF_LOW_BITS = 5;

    // ------------------------------------------------------------------
    // Location offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_M11_LO = 5'h00;
    localparam logic [4:0] ADDR_M11_HI = 5'h01;
    localparam logic [4:0] ADDR_M12_LO = 5'h02;
    localparam logic [4:0] ADDR_M13_LO = 5'h04;
    localparam logic [4:0] ADDR_M21_LO = 5'h06;
    localparam logic [4:0] ADDR_M22_LO = 5'h08;
    localparam logic [4:0] ADDR_M23_LO = 5'h0a;
    localparam logic [4:0] ADDR_M31_LO = 5'h0c;
    localparam logic [4:0] ADDR_M32_LO = 5'h0e;
    localparam logic [4:0] ADDR_M33_LO = 5'h10;
    localparam logic [4:0] ADDR_M33_HI = 5'h11;
    localparam logic [4:0] ADDR_KEY_LO = 5'h12;
    localparam logic [4:0] ADDR_KEY_HI = 5'h13;
    localparam logic [4:0] ADDR_PATH = 5'h14;
    localparam logic [4:0] ADDR_LEVEL = 5'h15;
    localparam logic [4:0] ADDR_LINK = 5'h16;

    // ------------------------------------------------------------------
    // Field masks and positions
    // ------------------------------------------------------------------
    localparam logic [7:0] LOW_LOC_MASK = 8'hf8;
    localparam logic [7:0] LINK_KEEP_MASK = 8'hf5;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam int PATH_OUT_IN = 7;
    localparam int PATH_INTERP = 6;
    localparam int PATH_BYPASS = 5;
    localparam int PATH_MUX_IN = 4;
    localparam int PATH_MUX_OUT = 3;
    localparam int PATH_CHROMA_RND = 2;
    localparam int PATH_FILT_RND = 1;
    localparam int PATH_FULL_RATE = 0;
    localparam int LINK_COPROC = 7;
    localparam int LINK_IN = 6;
    localparam int LINK_OUT = 5;
    localparam int LINK_CSPACE = 4;
    localparam int LINK_SYNC_OUT = 2;
    localparam int LINK_SLOW_CLK = 0;

    // ------------------------------------------------------------------
    // Reset values and synchroniser width
    // ------------------------------------------------------------------
    localparam logic [7:0] LOC_RESET = 8'h00;
    localparam int SYNC_W = 15;
    localparam logic [14:0] SYNC_RESET = 15'h4000;

endpackage : thrm_pkg

//--- hdl/thrm_sync.sv
// Two-stage synchroniser for the asynchronous host pins.
`timescale 1ns/100ps

module thrm_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pins and synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } thrm_sync_st_t;

    thrm_sync_st_t st_r;
    thrm_sync_st_t st_nxt;

    // The first stage feeds the second stage and nothing else.
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = d;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.stable;

endmodule : thrm_sync

//--- hdl/thrm_regs.sv
// Host-programmable coefficient and control memory of the transcoder.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`timescale 1ns/100ps

module thrm_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Host port pins
    input wire logic host_cs_n,
    input wire logic host_rw,
    input wire logic [4:0] host_addr,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    // Matrix coefficients and key scaler
    output logic [12:0] matrix_r1c1,
    output logic [12:0] matrix_r1c2,
    output logic [12:0] matrix_r1c3,
    output logic [12:0] matrix_r2c1,
    output logic [12:0] matrix_r2c2,
    output logic [12:0] matrix_r2c3,
    output logic [12:0] matrix_r3c1,
    output logic [12:0] matrix_r3c2,
    output logic [12:0] matrix_r3c3,
    output logic [12:0] key_scale,
    // Path control bits
    output logic out_in_sel,
    output logic interp_or_decim,
    output logic filter_bypass,
    output logic mux_in_sel,
    output logic mux_out_sel,
    output logic chroma_round_width,
    output logic filter_round_sel,
    output logic full_rate_out,
    // Level control bits
    output logic hblank_cfg_hi,
    output logic hblank_cfg_lo,
    output logic in_offset_hi,
    output logic in_offset_lo,
    output logic out_offset_hi,
    output logic out_offset_lo,
    output logic clip_depth_hi,
    output logic clip_depth_lo,
    // Link control bits
    output logic coproc_sync_source,
    output logic link_count_in,
    output logic link_count_out,
    output logic color_space_tag,
    output logic sync_signal_out_en,
    output logic slow_clock_mode
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [22:0][7:0] mem;
        logic cs_n_d;
        logic [7:0] rd_data;
        logic oe;
    } thrm_state_t;

    thrm_state_t st_r;
    thrm_state_t st_nxt;

    logic [14:0] sync_q;
    logic cs_n_s;
    logic rw_s;
    logic [4:0] addr_s;
    logic [7:0] din_s;
    logic cs_fall;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [12:0] coef_of(input logic [7:0] hi,
                                            input logic [7:0] lo);
        coef_of = {hi, lo[7:3]};
    endfunction : coef_of

    function automatic logic is_mapped(input logic [4:0] a);
        is_mapped = (a <= thrm_pkg::ADDR_LINK);
    endfunction : is_mapped

    // Don't-care bits of low locations and reserved link bits are never
    // stored, so reads give zero without any extra read-side masking.
    function automatic logic [7:0] loc_mask(input logic [4:0] a);
        if ((a <= thrm_pkg::ADDR_KEY_HI) && !a[0]) begin
            loc_mask = thrm_pkg::LOW_LOC_MASK;
        end else if (a == thrm_pkg::ADDR_LINK) begin
            loc_mask = thrm_pkg::LINK_KEEP_MASK;
        end else begin
            loc_mask = thrm_pkg::FULL_MASK;
        end
    endfunction : loc_mask

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    // Address, data and direction pass the same two stages as chip select,
    // so they stay aligned with the edge given the host's setup and hold.
    thrm_sync #(
        .W(thrm_pkg::SYNC_W),
        .RST_VAL(thrm_pkg::SYNC_RESET)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({host_cs_n, host_rw, host_addr, host_data_bus_in}),
        .q(sync_q)
    );

    assign cs_n_s = sync_q[14];
    assign rw_s = sync_q[13];
    assign addr_s = sync_q[12:8];
    assign din_s = sync_q[7:0];
    assign cs_fall = st_r.cs_n_d & ~cs_n_s;

    // ------------------------------------------------------------------
    // Access engine
    // ------------------------------------------------------------------
    // Accesses are taken only on the chip select edge; the video side
    // never gates them, so the host may program at any moment.
    always_comb begin
        st_nxt = st_r;
        st_nxt.cs_n_d = cs_n_s;
        st_nxt.oe = ~cs_n_s & rw_s;
        if (cs_fall && !rw_s) begin
            if (is_mapped(addr_s)) begin
                st_nxt.mem[addr_s] = din_s & loc_mask(addr_s);
            end
        end else if (cs_fall && rw_s) begin
            if (is_mapped(addr_s)) begin
                st_nxt.rd_data = st_r.mem[addr_s];
            end else begin
                st_nxt.rd_data = thrm_pkg::LOC_RESET;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.mem <= {thrm_pkg::NUM_LOC{thrm_pkg::LOC_RESET}};
            st_r.cs_n_d <= 1'b1;
            st_r.rd_data <= thrm_pkg::LOC_RESET;
            st_r.oe <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign host_data_bus_out = st_r.rd_data;
    assign host_data_bus_oe = st_r.oe;

    // ------------------------------------------------------------------
    // Coefficient outputs
    // ------------------------------------------------------------------
    assign matrix_r1c1 = coef_of(st_r.mem[1], st_r.mem[0]);
    assign matrix_r1c2 = coef_of(st_r.mem[3], st_r.mem[2]);
    assign matrix_r1c3 = coef_of(st_r.mem[5], st_r.mem[4]);
    assign matrix_r2c1 = coef_of(st_r.mem[7], st_r.mem[6]);
    assign matrix_r2c2 = coef_of(st_r.mem[9], st_r.mem[8]);
    assign matrix_r2c3 = coef_of(st_r.mem[11], st_r.mem[10]);
    assign matrix_r3c1 = coef_of(st_r.mem[13], st_r.mem[12]);
    assign matrix_r3c2 = coef_of(st_r.mem[15], st_r.mem[14]);
    assign matrix_r3c3 = coef_of(st_r.mem[17], st_r.mem[16]);
    assign key_scale = coef_of(st_r.mem[thrm_pkg::ADDR_KEY_HI],
                               st_r.mem[thrm_pkg::ADDR_KEY_LO]);

    // ------------------------------------------------------------------
    // Control word outputs
    // ------------------------------------------------------------------
    assign out_in_sel = st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_OUT_IN];
    assign interp_or_decim =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_INTERP];
    assign filter_bypass =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_BYPASS];
    assign mux_in_sel = st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_MUX_IN];
    assign mux_out_sel =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_MUX_OUT];
    assign chroma_round_width =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_CHROMA_RND];
    assign filter_round_sel =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_FILT_RND];
    assign full_rate_out =
        st_r.mem[thrm_pkg::ADDR_PATH][thrm_pkg::PATH_FULL_RATE];

    assign {hblank_cfg_hi, hblank_cfg_lo, in_offset_hi, in_offset_lo,
            out_offset_hi, out_offset_lo, clip_depth_hi, clip_depth_lo} =
        st_r.mem[thrm_pkg::ADDR_LEVEL];

    // The tag is stored as written; keeping it consistent with the output
    // colour space is left to the host, while reserved bits 3 and 1 are stored as zero.
    assign coproc_sync_source =
        st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_COPROC];
    assign link_count_in = st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_IN];
    assign link_count_out = st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_OUT];
    assign color_space_tag =
        st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_CSPACE];
    assign sync_signal_out_en =
        st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_SYNC_OUT];
    assign slow_clock_mode =
        st_r.mem[thrm_pkg::ADDR_LINK][thrm_pkg::LINK_SLOW_CLK];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    write_store_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_PATH
        |=> st_r.mem[thrm_pkg::ADDR_PATH] == $past(din_s))
        else $error("Path word not stored on chip select edge.");

    read_return_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && rw_s && addr_s == thrm_pkg::ADDR_LEVEL
        |=> host_data_bus_out == st_r.mem[thrm_pkg::ADDR_LEVEL]
            && host_data_bus_oe)
        else $error("Read did not return the level word.");

    bus_float_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cs_n_s || !rw_s) |=> !host_data_bus_oe)
        else $error("Data bus driven while deselected or writing.");

    low_clear_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_M22_LO
        |=> st_r.mem[8][2:0] == 3'h0
            && st_r.mem[8][7:3] == $past(din_s[7:3]))
        else $error("Low location stored wrong bits.");

    read_low_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && rw_s && !addr_s[0] && addr_s <= thrm_pkg::ADDR_KEY_LO
        |=> host_data_bus_out[2:0] == 3'h0)
        else $error("Low location read gave nonzero low bits.");

    coef_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_M33_HI
        |=> matrix_r3c3[12:5] == $past(din_s))
        else $error("Last matrix term high bits wrong.");

    key_low_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_KEY_LO
        |=> key_scale[4:0] == $past(din_s[7:3]))
        else $error("Key scaler low bits wrong.");

    path_bit_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_PATH
        |=> interp_or_decim == $past(din_s[6])
            && full_rate_out == $past(din_s[0]))
        else $error("Path control bits misplaced.");

    level_bits_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_LEVEL
        |=> {hblank_cfg_hi, in_offset_lo, clip_depth_lo}
            == {$past(din_s[7]), $past(din_s[4]), $past(din_s[0])})
        else $error("Level control bits misplaced.");

    link_bits_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_LINK
        |=> sync_signal_out_en == $past(din_s[2])
            && st_r.mem[thrm_pkg::ADDR_LINK][3] == 1'b0)
        else $error("Link control word stored wrong.");

    mem_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !(cs_fall && !rw_s) |=> $stable(st_r.mem))
        else $error("Memory changed without a write edge.");

    oe_on_read_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && rw_s |=> host_data_bus_oe)
        else $error("Data bus not driven after a read edge.");

    unmapped_read_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && rw_s && !is_mapped(addr_s)
        |=> host_data_bus_out == thrm_pkg::LOC_RESET)
        else $error("Unmapped read did not return zero.");

    unmapped_write_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && !is_mapped(addr_s) |=> $stable(st_r.mem))
        else $error("Unmapped write changed the memory.");

    first_low_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_M11_LO
        |=> matrix_r1c1[4:0] == $past(din_s[7:3]))
        else $error("First matrix term low bits wrong.");

    first_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_M11_HI
        |=> matrix_r1c1[12:5] == $past(din_s))
        else $error("First matrix term high bits wrong.");

    key_high_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_KEY_HI
        |=> key_scale[12:5] == $past(din_s))
        else $error("Key scaler high bits wrong.");

    path_rest_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_PATH
        |=> {out_in_sel, filter_bypass, mux_in_sel, mux_out_sel,
             chroma_round_width, filter_round_sel}
            == {$past(din_s[7]), $past(din_s[5:1])})
        else $error("Path control upper bits misplaced.");

    level_rest_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_LEVEL
        |=> {hblank_cfg_lo, in_offset_hi, out_offset_hi, out_offset_lo,
             clip_depth_hi}
            == {$past(din_s[6]), $past(din_s[5]), $past(din_s[3:1])})
        else $error("Level control fields misplaced.");

    link_rest_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cs_fall && !rw_s && addr_s == thrm_pkg::ADDR_LINK
        |=> {coproc_sync_source, link_count_in, link_count_out,
             color_space_tag, slow_clock_mode}
            == {$past(din_s[7:4]), $past(din_s[0])})
        else $error("Link control bits misplaced.");

    read_hold_a: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !cs_fall |=> $stable(host_data_bus_out))
        else $error("Read data changed without a read edge.");

endmodule : thrm_regs

//--- sim/thrm_host_model.sv
// Host processor model that drives the asynchronous register port.
`timescale 1ns/100ps

module thrm_host_model (
    // Clock
    input wire logic core_clk,
    // Host port pins
    output logic host_cs_n,
    output logic host_rw,
    output logic [4:0] host_addr,
    output logic [7:0] host_data_bus_in,
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe
);
    logic drv_en;
    logic [7:0] drv_val;
    logic [7:0] last_val;

    // A released bus shows the inverse of its last value, never a stale copy.
    assign host_data_bus_in = drv_en ? drv_val :
        (host_data_bus_oe ? host_data_bus_out : ~last_val);

    initial begin
        host_cs_n = 1'b1;
        host_rw = 1'b1;
        host_addr = 5'h00;
        drv_en = 1'b0;
        drv_val = 8'h00;
        last_val = 8'h00;
    end

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Pins settle one cycle ahead of chip select and hold four cycles after.
    task automatic write_loc(input logic [4:0] a, input logic [7:0] d);
        @(negedge core_clk);
        host_rw = 1'b0;
        host_addr = a;
        drv_val = (a == 5'h16) ? (d & 8'hf5) : d;
        drv_en = 1'b1;
        @(negedge core_clk);
        host_cs_n = 1'b0;
        repeat (4) @(negedge core_clk);
        host_cs_n = 1'b1;
        last_val = drv_val;
        drv_en = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : write_loc

    task automatic read_loc(input logic [4:0] a, output logic [7:0] d,
                            output logic ok);
        int n;
        @(negedge core_clk);
        host_rw = 1'b1;
        host_addr = a;
        @(negedge core_clk);
        host_cs_n = 1'b0;
        ok = 1'b0;
        d = 8'h00;
        for (n = 0; n < 8 && !ok; n++) begin
            @(negedge core_clk);
            if (host_data_bus_oe === 1'b1) begin
                ok = 1'b1;
                d = host_data_bus_in;
            end
        end
        host_cs_n = 1'b1;
        last_val = d;
        repeat (3) @(negedge core_clk);
    endtask : read_loc

endmodule : thrm_host_model

//--- sim/transcoder_host_register_map_tb_top.sv
// Self-checking bench for the transcoder host register map.
`timescale 1ns/100ps

module transcoder_host_register_map_tb_top;
    logic core_clk;
    logic rst_n;
    logic host_cs_n;
    logic host_rw;
    logic [4:0] host_addr;
    logic [7:0] host_data_bus_in;
    logic [7:0] host_data_bus_out;
    logic host_data_bus_oe;
    logic [12:0] coef [10];
    logic [7:0] path_w;
    logic [7:0] level_w;
    logic [7:0] link_w;
    logic [7:0] exp_mem [32];
    logic [7:0] rnd;
    logic [7:0] rd;
    logic ok;
    int error_cnt;
    int checks_done;
    int i;

    assign link_w[3] = 1'b0;
    assign link_w[1] = 1'b0;

    thrm_regs DUT (
        .core_clk(core_clk), .rst_n(rst_n), .host_cs_n(host_cs_n),
        .host_rw(host_rw), .host_addr(host_addr),
        .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe),
        .matrix_r1c1(coef[0]), .matrix_r1c2(coef[1]), .matrix_r1c3(coef[2]),
        .matrix_r2c1(coef[3]), .matrix_r2c2(coef[4]), .matrix_r2c3(coef[5]),
        .matrix_r3c1(coef[6]), .matrix_r3c2(coef[7]), .matrix_r3c3(coef[8]),
        .key_scale(coef[9]), .out_in_sel(path_w[7]),
        .interp_or_decim(path_w[6]), .filter_bypass(path_w[5]),
        .mux_in_sel(path_w[4]), .mux_out_sel(path_w[3]),
        .chroma_round_width(path_w[2]), .filter_round_sel(path_w[1]),
        .full_rate_out(path_w[0]), .hblank_cfg_hi(level_w[7]),
        .hblank_cfg_lo(level_w[6]), .in_offset_hi(level_w[5]),
        .in_offset_lo(level_w[4]), .out_offset_hi(level_w[3]),
        .out_offset_lo(level_w[2]), .clip_depth_hi(level_w[1]),
        .clip_depth_lo(level_w[0]), .coproc_sync_source(link_w[7]),
        .link_count_in(link_w[6]), .link_count_out(link_w[5]),
        .color_space_tag(link_w[4]), .sync_signal_out_en(link_w[2]),
        .slow_clock_mode(link_w[0])
    );

    thrm_host_model host (
        .core_clk(core_clk), .host_cs_n(host_cs_n), .host_rw(host_rw),
        .host_addr(host_addr), .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Expectations and checks
    // ------------------------------------------------------------------
    // Bits a location keeps; unmapped places keep nothing.
    function automatic logic [7:0] loc_mask(input logic [4:0] a);
        if (a > 5'h16) return 8'h00;
        if (a == 5'h16) return 8'hf5;
        if (a <= 5'h12 && !a[0]) return 8'hf8;
        return 8'hff;
    endfunction : loc_mask

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic check8(input logic [7:0] got, input logic [7:0] expv);
        checks_done++;
        if (got !== expv) begin
            error_cnt++;
            $display("BAD %0t byte got %h want %h", $time, got, expv);
        end
    endtask : check8

    task automatic check13(input logic [12:0] got, input logic [12:0] expv);
        checks_done++;
        if (got !== expv) begin
            error_cnt++;
            $display("BAD %0t coef got %h want %h", $time, got, expv);
        end
    endtask : check13

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host.write_loc(a, d);
        exp_mem[a] = d & loc_mask(a);
        check8({7'h00, host_data_bus_oe}, 8'h00);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a);
        host.read_loc(a, rd, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t read got no answer", $time);
            end_sim();
        end
        check8(rd, exp_mem[a]);
        @(negedge core_clk);
        check8({7'h00, host_data_bus_oe}, 8'h00);
    endtask : rd_chk

    task automatic check_ports();
        int k;
        for (k = 0; k < 10; k++) begin
            check13(coef[k], {exp_mem[2*k+1], exp_mem[2*k][7:3]});
        end
        check8(path_w, exp_mem[20]);
        check8(level_w, exp_mem[21]);
        check8(link_w, exp_mem[22]);
    endtask : check_ports

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        rnd = 8'h5c;
        for (i = 0; i < 32; i++) exp_mem[i] = 8'h00;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check_ports();
        // Descending order shows the map needs no sequence.
        for (i = 22; i >= 0; i--) begin
            rnd = lfsr(rnd);
            wr(5'(i), rnd);
        end
        check_ports();
        for (i = 0; i < 23; i++) wr(5'(i), 8'hff);
        check_ports();
        for (i = 0; i < 32; i++) rd_chk(5'(i));
        wr(5'h1f, 8'ha5);
        rd_chk(5'h1f);
        wr(5'h14, exp_mem[20] ^ 8'h10);
        check_ports();
        wr(5'h08, 8'h00);
        check_ports();
        wr(5'h16, 8'h95);
        check_ports();
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            wr(rnd[4:0] % 5'h17, lfsr(rnd));
            rd_chk(rnd[4:0] % 5'h17);
        end
        check_ports();
        // A second reset in mid-run must clear every location again.
        @(negedge core_clk);
        rst_n = 1'b0;
        for (i = 0; i < 32; i++) exp_mem[i] = 8'h00;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check_ports();
        rd_chk(5'h14);
        end_sim();
    end

endmodule : transcoder_host_register_map_tb_top
